// ==== logic/ddtf_pkg.sv ====
// Purpose: Shared constants for the debug data-transfer flow block
// Assumes: 32-bit transfer words, single clock
// Notes:   Access-mode field is two bits wide
package ddtf_pkg;
    localparam int          DATA_W          = 32;
    localparam int          MODE_W          = 2;
    localparam logic [1:0]  MODE_NONBLOCK   = 2'h0;
    localparam logic [31:0] DATA_RESET      = 32'h0000_0000;
    localparam logic        FLAG_RESET      = 1'b0;
endpackage

// ==== logic/ddtf_flow.sv ====
// Purpose: Flow control of the debug data-transfer channel (receive and transmit words)
// Assumes: All strobes are one-cycle pulses from logic on clock_i
// Notes:   Latched rx flag gates host rx writes only in non-blocking mode; other modes pass writes ungated
`timescale 1ns/1ps
`default_nettype none
// Function
// - Keep latched rx and tx full flags
// - Core rx read clears live flag only
// - Host rx write ignored if latched full in non-blocking mode
// - Status read copies live rx into latched
// - Host rx write refreshes latched rx flag
// - Status or tx read refreshes latched tx
// - Mode value zero means non-blocking
module ddtf_flow (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic [1:0]  host_access_mode_i,
    input  wire logic        host_status_rd_i,
    input  wire logic        host_rx_wr_i,
    input  wire logic [31:0] host_rx_wdata_i,
    input  wire logic        host_tx_rd_i,
    input  wire logic        core_rx_rd_i,
    input  wire logic        core_tx_wr_i,
    input  wire logic [31:0] core_tx_wdata_i,
    output logic [31:0]      rx_reg_core_view_o,
    output logic [31:0]      tx_reg_host_view_o,
    output logic             rx_full_live_o,
    output logic             tx_full_live_o,
    output logic             rx_full_latched_o,
    output logic             tx_full_latched_o,
    output logic             host_rx_wr_dropped_o
);
    logic [31:0] rx_data_reg, rx_data_next;
    logic [31:0] tx_data_reg, tx_data_next;
    logic        rx_live_reg, rx_live_next;
    logic        tx_live_reg, tx_live_next;
    logic        rx_lat_reg,  rx_lat_next;
    logic        tx_lat_reg,  tx_lat_next;
    logic        drop_reg,    drop_next;
    logic        nonblock;
    logic        rx_accept;

    always_comb begin
        nonblock  = (host_access_mode_i == ddtf_pkg::MODE_NONBLOCK);
        rx_accept = host_rx_wr_i && !(nonblock && rx_lat_reg);
        rx_data_next = rx_data_reg;
        tx_data_next = tx_data_reg;
        rx_live_next = rx_live_reg;
        tx_live_next = tx_live_reg;
        rx_lat_next  = rx_lat_reg;
        tx_lat_next  = tx_lat_reg;
        drop_next    = host_rx_wr_i && !rx_accept;
        // Core read clears live; an accepted host write sets it afterwards, so the set wins
        if (core_rx_rd_i) begin
            rx_live_next = 1'b0;
        end
        if (rx_accept) begin
            rx_data_next = host_rx_wdata_i;
            rx_live_next = 1'b1;
        end
        if (host_tx_rd_i) begin
            tx_live_next = 1'b0;
        end
        if (core_tx_wr_i) begin
            tx_data_next = core_tx_wdata_i;
            tx_live_next = 1'b1;
        end
        // Latched flags take the live value: current on a status read, updated on an rx write or tx read
        if (host_status_rd_i) begin
            rx_lat_next = rx_live_reg;
        end
        if (host_rx_wr_i) begin
            rx_lat_next = rx_live_next;
        end
        if (host_status_rd_i || host_tx_rd_i) begin
            tx_lat_next = host_tx_rd_i ? tx_live_next : tx_live_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rx_data_reg <= ddtf_pkg::DATA_RESET;
            tx_data_reg <= ddtf_pkg::DATA_RESET;
            rx_live_reg <= ddtf_pkg::FLAG_RESET;
            tx_live_reg <= ddtf_pkg::FLAG_RESET;
            rx_lat_reg  <= ddtf_pkg::FLAG_RESET;
            tx_lat_reg  <= ddtf_pkg::FLAG_RESET;
            drop_reg    <= 1'b0;
        end else begin
            rx_data_reg <= rx_data_next;
            tx_data_reg <= tx_data_next;
            rx_live_reg <= rx_live_next;
            tx_live_reg <= tx_live_next;
            rx_lat_reg  <= rx_lat_next;
            tx_lat_reg  <= tx_lat_next;
            drop_reg    <= drop_next;
        end
    end

    assign rx_reg_core_view_o   = rx_data_reg;
    assign tx_reg_host_view_o   = tx_data_reg;
    assign rx_full_live_o       = rx_live_reg;
    assign tx_full_live_o       = tx_live_reg;
    assign rx_full_latched_o    = rx_lat_reg;
    assign tx_full_latched_o    = tx_lat_reg;
    assign host_rx_wr_dropped_o = drop_reg;

    rx_drop_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && rx_lat_reg && host_access_mode_i == 2'h0) |=> $stable(rx_data_reg) && drop_reg)
        else $error("rx write passed while latched full");
    rx_load_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && !rx_lat_reg) |=> rx_live_reg && rx_data_reg == $past(host_rx_wdata_i))
        else $error("accepted rx write not loaded");
    core_rd_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (core_rx_rd_i && !host_rx_wr_i && !host_status_rd_i) |=> !rx_live_reg && rx_lat_reg == $past(rx_lat_reg))
        else $error("core rx read wrong");
    stat_rx_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_status_rd_i && !host_rx_wr_i) |=> rx_lat_reg == $past(rx_live_reg))
        else $error("status read missed rx latch");
    wr_lat_a : assert property (@(posedge clock_i) disable iff (reset_i)
        host_rx_wr_i |=> rx_lat_reg == rx_live_reg)
        else $error("rx write did not refresh latch");
    tx_lat_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_status_rd_i && !host_tx_rd_i) |=> tx_lat_reg == $past(tx_live_reg))
        else $error("status read missed tx latch");
    tx_set_a : assert property (@(posedge clock_i) disable iff (reset_i)
        core_tx_wr_i |=> tx_live_reg && tx_data_reg == $past(core_tx_wdata_i))
        else $error("core tx write lost");
    tx_clr_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_tx_rd_i && !core_tx_wr_i) |=> !tx_live_reg && !tx_lat_reg)
        else $error("host tx read did not clear");
    lat_hold_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (!host_status_rd_i && !host_rx_wr_i) |=> $stable(rx_lat_reg))
        else $error("rx latch moved without host access");
    mode_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && host_access_mode_i != 2'h0) |=> rx_live_reg && !drop_reg)
        else $error("non-zero mode gated rx write");

    // Checks on hold and edge cases of the flags and the rx and tx data words
    rx_keep_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && rx_lat_reg && host_access_mode_i == ddtf_pkg::MODE_NONBLOCK && !core_rx_rd_i)
        |=> rx_live_reg == $past(rx_live_reg))
        else $error("refused rx write moved live flag");

    drop_only_a : assert property (@(posedge clock_i) disable iff (reset_i)
        !host_rx_wr_i |=> !drop_reg)
        else $error("drop pulse without rx write");

    drop_lat_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && rx_lat_reg && host_access_mode_i == ddtf_pkg::MODE_NONBLOCK && !core_rx_rd_i)
        |=> rx_lat_reg == $past(rx_live_reg))
        else $error("refused rx write did not refresh latch");

    rx_data_hold_a : assert property (@(posedge clock_i) disable iff (reset_i)
        !host_rx_wr_i |=> $stable(rx_data_reg))
        else $error("rx word changed without write");

    tx_data_hold_a : assert property (@(posedge clock_i) disable iff (reset_i)
        !core_tx_wr_i |=> $stable(tx_data_reg))
        else $error("tx word changed without write");

    rx_set_only_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (!host_rx_wr_i && !rx_live_reg) |=> !rx_live_reg)
        else $error("rx live set without write");

    tx_set_only_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (!core_tx_wr_i && !tx_live_reg) |=> !tx_live_reg)
        else $error("tx live set without write");

    rx_clr_only_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (!core_rx_rd_i && rx_live_reg) |=> rx_live_reg)
        else $error("rx live cleared without core read");

    tx_clr_only_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (!host_tx_rd_i && tx_live_reg) |=> tx_live_reg)
        else $error("tx live cleared without host read");

    tx_hold_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (!host_status_rd_i && !host_tx_rd_i) |=> $stable(tx_lat_reg))
        else $error("tx latch moved without host access");

    tx_rd_lat_a : assert property (@(posedge clock_i) disable iff (reset_i)
        host_tx_rd_i |=> tx_lat_reg == tx_live_reg)
        else $error("tx read did not refresh latch");

    wr_win_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && core_rx_rd_i && !rx_lat_reg) |=> rx_live_reg)
        else $error("core read beat accepted rx write");

    tx_win_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (core_tx_wr_i && host_tx_rd_i) |=> tx_live_reg && tx_lat_reg)
        else $error("host read beat core tx write");

    stat_clr_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_status_rd_i && !host_rx_wr_i && !rx_live_reg) |=> !rx_lat_reg)
        else $error("status read kept stale rx latch");

    stat_set_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_status_rd_i && !host_rx_wr_i && rx_live_reg) |=> rx_lat_reg)
        else $error("status read missed full rx");

    open_drop_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_access_mode_i != ddtf_pkg::MODE_NONBLOCK) |=> !drop_reg)
        else $error("rx write dropped outside non-blocking mode");

    open_load_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && host_access_mode_i != ddtf_pkg::MODE_NONBLOCK) |=> rx_data_reg == $past(host_rx_wdata_i))
        else $error("rx word not loaded outside non-blocking mode");

    lat_gate_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_rx_wr_i && !rx_lat_reg) |=> !drop_reg)
        else $error("rx write dropped with latch clear");

    tx_stat_set_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_status_rd_i && !host_tx_rd_i && tx_live_reg) |=> tx_lat_reg)
        else $error("status read missed full tx");

    tx_stat_clr_a : assert property (@(posedge clock_i) disable iff (reset_i)
        (host_status_rd_i && !host_tx_rd_i && !tx_live_reg) |=> !tx_lat_reg)
        else $error("status read kept stale tx latch");

endmodule // ddtf_flow
`default_nettype wire

// ==== dv/ddtf_host_model.sv ====
// Purpose: Debugger side: one host access a cycle
// Assumes: Strobes change at the falling edge
// Notes:   lax_i lets transfers skip the status read
`timescale 1ns/1ps
`default_nettype none
module ddtf_host_model (
    input  wire logic   clock_i,
    input  wire logic   lax_i,
    output logic        st_o,
    output logic        wr_o,
    output logic [31:0] wd_o,
    output logic        rd_o
);
    integer seed = 79;
    int     pick;
    logic   seen = 1'b0;
    initial {st_o, wr_o, rd_o, wd_o} = '0;
    always @(negedge clock_i) begin
        pick = int'($unsigned($random(seed)) % 4);
        if (pick > 1 && !seen && !lax_i) pick = 1;
        st_o <= (pick == 1);
        wr_o <= (pick == 2);
        rd_o <= (pick == 3);
        wd_o <= $random(seed);
        seen <= (pick == 1);
    end
endmodule // ddtf_host_model
`default_nettype wire

// ==== dv/test_debug_data_transfer_flow.sv ====
// Purpose: Random checks of the flow flags against a reference
// Assumes: Core strobes never coincide with a status read
// Notes:   Strict, lax, then any mode
`timescale 1ns/1ps
`default_nettype none
module test_debug_data_transfer_flow;
    logic clock_i = 0, reset_i = 1, lax = 0, crd = 0, cwr = 0, st, wr, rd, rxl, txl, rxa, txa, dr;
    logic e_rxl, e_txl, e_rxa, e_txa, e_dr, acc, nrx, ntx;
    logic [1:0] mode = 0;
    logic [31:0] cwd = 0, wd, rxd, txd, e_rxd, e_txd;
    integer seed = 79, n_errors = 0, tests_run = 0, cyc = 0;
    wire c_rd = crd & !st;
    wire c_wr = cwr & !st;
    ddtf_host_model host (.clock_i(clock_i), .lax_i(lax), .st_o(st), .wr_o(wr), .wd_o(wd), .rd_o(rd));
    ddtf_flow dut (.clock_i(clock_i), .reset_i(reset_i), .host_access_mode_i(mode), .host_status_rd_i(st),
        .host_rx_wr_i(wr), .host_rx_wdata_i(wd), .host_tx_rd_i(rd), .core_rx_rd_i(c_rd), .core_tx_wr_i(c_wr),
        .core_tx_wdata_i(cwd), .rx_reg_core_view_o(rxd), .tx_reg_host_view_o(txd), .rx_full_live_o(rxl),
        .tx_full_live_o(txl), .rx_full_latched_o(rxa), .tx_full_latched_o(txa), .host_rx_wr_dropped_o(dr));
    task automatic complete_run;
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    always #10 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            complete_run;
        end
        acc = wr && !(mode == ddtf_pkg::MODE_NONBLOCK && e_rxa);
        nrx = acc | (e_rxl & !c_rd);
        ntx = c_wr | (e_txl & !rd);
        if (reset_i) {e_rxl, e_txl, e_rxa, e_txa, e_dr, e_rxd, e_txd} <= '0;
        else begin
            {e_rxl, e_txl, e_dr} <= {nrx, ntx, wr & !acc};
            if (wr | st) e_rxa <= nrx;
            if (rd | st) e_txa <= ntx;
            if (acc) e_rxd <= wd;
            if (c_wr) e_txd <= cwd;
        end
    end
    initial begin
        repeat (16) @(negedge clock_i);
        reset_i = 0;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clock_i);
            check({59'h0, rxl, txl, rxa, txa, dr}, {59'h0, e_rxl, e_txl, e_rxa, e_txa, e_dr});
            check({rxd, txd}, {e_rxd, e_txd});
            lax = i >= 1000;
            mode = (i < 2000) ? ddtf_pkg::MODE_NONBLOCK : 2'($random(seed));
            crd = 1'($random(seed));
            cwr = 1'($random(seed));
            cwd = $random(seed);
        end
        complete_run;
    end
endmodule // test_debug_data_transfer_flow
`default_nettype wire
